// *** core/sysctl_params.svh ***
// Constants for the reset-control and sleep-control register pair.
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// Register byte offsets on the APB
`define OFS_APP_CTRL 12'h000
`define OFS_SLEEP_CTRL 12'h004

// Write key and key status pattern
`define WRITE_KEY 16'h05FA
`define KEY_STATUS 16'hFA05
`define KEY_HI 31
`define KEY_LO 16

// Application control field positions
`define BYTE_ORDER_BIT 15
`define SEC_PRIO_BIT 14
`define FAULT_NS_BIT 13
`define RST_RESTRICT_BIT 3
`define RST_REQ_BIT 2
`define CLR_ACTIVE_BIT 1

// Sleep control field positions
`define WAKE_PEND_BIT 4
`define DEEP_LOCK_BIT 3
`define DEEP_SEL_BIT 2
`define EXIT_SLEEP_BIT 1

// Reset value of every stored control bit
`define CTRL_RESET 1'b0

// Security extension present by default
`define SEC_EXT_DEFAULT 1'b1

// 1: restriction bit hidden from Non-secure; 0: hidden from Secure
`define RESTRICT_HIDE_NS 1'b1

`endif

// *** core/sysctl_pkg.sv ***
// Types for the reset-control and sleep-control register pair.
package sysctl_pkg;

    typedef enum logic [1:0] {
        WFE_RUN = 2'b00,
        WFE_WAIT = 2'b01,
        WFE_WAKE = 2'b11
    } wfe_state_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic slverr;
        logic strap_done;
        logic byte_order;
        logic sec_prio;
        logic fault_ns;
        logic rst_restrict;
        logic rst_req;
        logic clr_active;
        logic wake_pend_s;
        logic wake_pend_ns;
        logic deep_lock;
        logic deep_sel;
        logic exit_sleep_s;
        logic exit_sleep_ns;
        logic evt_latched;
        logic sleep_req;
        wfe_state_t wait_for_event_instr;
    } state_t;

endpackage : sysctl_pkg

// *** core/system_control_reset_sleep_regs.sv ***
// APB register pair for reset control, exception ranking and sleep control.
//
// How it works
// - Writes to the reset control register are dropped unless the key matches.
// - Reads of the reset control register return the key status pattern on top.
// - Key, byte order, ranking, fault, reset and clear bits have one shared copy.
// - Secure priority bit set lowers Non-secure exceptions; clear keeps ranges equal.
// - Without the security extension, ranking and fault bits read zero, unwritable.
// - Fault target bit set moves bus fault and NMI to Non-secure.
// - Restriction bit set lets only Secure state request a system reset.
// - Restriction bit reads zero and ignores writes from the hidden state.
// - Keyed write of one to the request bit asks for system reset.
// - Clear-active bit is write-only and acts only while the core is halted.
// - Each register has a Secure and a Non-secure view, shared or banked per bit.
// - Wake-on-pending set lets every new pending interrupt wake the core.
// - A new event wakes a waiting core, else is latched for the next wait.
// - Send-event instruction or external event input also wakes the core.
// - Deep sleep lock set hides the deep sleep select from Non-secure state.
// - Deep sleep select chooses ordinary sleep at zero, deep sleep at one.
// - Sleep-after-handler set requests sleep on return to Thread mode.
// - Wake-on-pending and sleep-after-handler bits have one copy per security state.
//
// Register access over APB and the address map are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

`include "sysctl_params.svh"

module system_control_reset_sleep_regs #(
    parameter bit security_ext = `SEC_EXT_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Core status
    input wire logic big_endian_strap,
    input wire logic cpu_secure,
    input wire logic cpu_halted,

    // Wake sources and sleep triggers
    input wire logic irq_became_pending,
    input wire logic irq_en_became_pending,
    input wire logic sev_exec,
    input wire logic ext_event,
    input wire logic wfe_exec,
    input wire logic handler_return_thread,

    // Exception control
    output logic big_endian,
    output logic nonsecure_deprioritized,
    output logic fault_target_nonsecure,
    output logic reset_secure_only,

    // Reset control
    output logic sys_reset_request,
    output logic clear_active_pulse,

    // Low power control
    output var sysctl_pkg::wfe_state_t wfe_state,
    output logic wfe_wake,
    output logic event_latched,
    output logic deep_sleep,
    output logic sleep_on_exit_req
);

    import sysctl_pkg::*;

    state_t s;
    state_t next_s;

    logic [31:0] lane_mask;
    logic [31:0] wbits;
    logic [31:0] rd_word;
    logic setup;
    logic access;
    logic hit_app;
    logic hit_sleep;
    logic sec_acc;
    logic key_ok;
    logic wr_app;
    logic wr_sleep;
    logic restrict_vis;
    logic deep_vis;
    logic wake_pend_cur;
    logic exit_sleep_cur;
    logic evt;
    logic [31:0] app_view;
    logic [31:0] sleep_view_s;
    logic [31:0] sleep_view_ns;
    logic wen_prio_fault;
    logic wen_restrict;
    logic set_rst_req;
    logic set_clr_active;
    logic wen_sleep_s;
    logic wen_sleep_ns;
    logic wen_deep_sel;

    // Byte enables turn into a per-bit write mask
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_lane
            assign lane_mask[g*8 +: 8] = {8{pstrb[g]}};
        end
    endgenerate

    assign wbits = pwdata & lane_mask;

    // Zero wait state: the access phase always completes
    assign pready = 1'b1;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_app = (paddr == `OFS_APP_CTRL);
    assign hit_sleep = (paddr == `OFS_SLEEP_CTRL);

    // Without the extension every access counts as Secure
    assign sec_acc = ~security_ext | ~pprot[1];

    // Both key byte lanes must be enabled, else a partial key could slip in
    assign key_ok = (pwdata[`KEY_HI:`KEY_LO] == `WRITE_KEY) & pstrb[3] & pstrb[2];

    assign wr_app = access & pwrite & hit_app & key_ok;
    assign wr_sleep = access & pwrite & hit_sleep;

    // The restriction bit is visible only in one state
    assign restrict_vis = `RESTRICT_HIDE_NS ? sec_acc : ~sec_acc;

    assign deep_vis = sec_acc | ~s.deep_lock;

    // Per-field write enables; a field moves only when its own byte lane is enabled
    assign wen_prio_fault = wr_app & security_ext & sec_acc & pstrb[1];
    assign wen_restrict = wr_app & restrict_vis & pstrb[0];
    // Only Secure may request once the restriction bit is set
    assign set_rst_req = wr_app & wbits[`RST_REQ_BIT] & (sec_acc | ~s.rst_restrict);
    // Clear-active outside Halt is dropped, not deferred
    assign set_clr_active = wr_app & wbits[`CLR_ACTIVE_BIT] & cpu_halted;
    assign wen_sleep_s = wr_sleep & pstrb[0] & sec_acc;
    assign wen_sleep_ns = wr_sleep & pstrb[0] & ~sec_acc;
    assign wen_deep_sel = wr_sleep & pstrb[0] & deep_vis;

    // Banked copies selected by the state the core runs in
    assign wake_pend_cur = cpu_secure ? s.wake_pend_s : s.wake_pend_ns;
    assign exit_sleep_cur = cpu_secure ? s.exit_sleep_s : s.exit_sleep_ns;

    // Disabled interrupts count as wake sources only with wake-on-pending
    always_comb begin
        evt = sev_exec | ext_event;
        if (wake_pend_cur) begin
            evt = evt | irq_became_pending;
        end else begin
            evt = evt | irq_en_became_pending;
        end
    end

    // Shared view of the reset control register; one copy serves both states
    always_comb begin
        app_view = 32'h0000_0000;
        app_view[`KEY_HI:`KEY_LO] = `KEY_STATUS;
        app_view[`BYTE_ORDER_BIT] = s.byte_order;
        app_view[`SEC_PRIO_BIT] = s.sec_prio;
        app_view[`FAULT_NS_BIT] = s.fault_ns;
        app_view[`RST_RESTRICT_BIT] = s.rst_restrict & restrict_vis;
        app_view[`RST_REQ_BIT] = s.rst_req;
        // Clear-active is write-only and reads as zero
    end

    // Secure view of the sleep control register
    always_comb begin
        sleep_view_s = 32'h0000_0000;
        sleep_view_s[`WAKE_PEND_BIT] = s.wake_pend_s;
        sleep_view_s[`DEEP_LOCK_BIT] = s.deep_lock;
        sleep_view_s[`DEEP_SEL_BIT] = s.deep_sel;
        sleep_view_s[`EXIT_SLEEP_BIT] = s.exit_sleep_s;
    end

    // Non-secure view; the lock bit is Secure only and reads as zero here
    always_comb begin
        sleep_view_ns = 32'h0000_0000;
        sleep_view_ns[`WAKE_PEND_BIT] = s.wake_pend_ns;
        sleep_view_ns[`DEEP_SEL_BIT] = s.deep_sel & deep_vis;
        sleep_view_ns[`EXIT_SLEEP_BIT] = s.exit_sleep_ns;
    end

    // Read multiplexer, seen in the setup phase; reserved positions stay zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_app) begin
            rd_word = app_view;
        end else if (hit_sleep && sec_acc) begin
            rd_word = sleep_view_s;
        end else if (hit_sleep) begin
            rd_word = sleep_view_ns;
        end
    end

    always_comb begin
        next_s = s;
        next_s.clr_active = 1'b0;
        next_s.sleep_req = 1'b0;

        // Byte order strap caught on the first edge after release
        if (!s.strap_done) begin
            next_s.byte_order = big_endian_strap;
            next_s.strap_done = 1'b1;
        end

        // Read data and error registered for the access phase
        if (setup) begin
            next_s.rdata = rd_word;
            next_s.slverr = ~(hit_app | hit_sleep);
        end

        // Shared bits: one copy for both views
        if (wen_prio_fault) begin
            next_s.sec_prio = wbits[`SEC_PRIO_BIT];
            next_s.fault_ns = wbits[`FAULT_NS_BIT];
        end
        if (wen_restrict) begin
            next_s.rst_restrict = wbits[`RST_RESTRICT_BIT];
        end
        // Request is sticky; a zero asks for nothing
        if (set_rst_req) begin
            next_s.rst_req = 1'b1;
        end
        if (set_clr_active) begin
            next_s.clr_active = 1'b1;
        end

        // Banked wake and exit copies: the access's own state picks the copy; deep lock and select have one copy
        if (wen_sleep_s) begin
            next_s.wake_pend_s = wbits[`WAKE_PEND_BIT];
            next_s.exit_sleep_s = wbits[`EXIT_SLEEP_BIT];
            next_s.deep_lock = wbits[`DEEP_LOCK_BIT];
        end
        if (wen_sleep_ns) begin
            next_s.wake_pend_ns = wbits[`WAKE_PEND_BIT];
            next_s.exit_sleep_ns = wbits[`EXIT_SLEEP_BIT];
        end
        if (wen_deep_sel) begin
            next_s.deep_sel = wbits[`DEEP_SEL_BIT];
        end

        // Sleep on return from a handler to Thread mode
        if (handler_return_thread && exit_sleep_cur) begin
            next_s.sleep_req = 1'b1;
        end

        // Wait-for-event sequencer
        case (s.wait_for_event_instr)
            WFE_RUN: begin
                if (wfe_exec) begin
                    if (s.evt_latched || evt) begin
                        next_s.wait_for_event_instr = WFE_WAKE;
                        next_s.evt_latched = 1'b0;
                    end else begin
                        next_s.wait_for_event_instr = WFE_WAIT;
                    end
                end else if (evt) begin
                    next_s.evt_latched = 1'b1;
                end
            end
            WFE_WAIT: begin
                if (evt) begin
                    next_s.wait_for_event_instr = WFE_WAKE;
                end
            end
            WFE_WAKE: begin
                // An event landing on the wake cycle is kept for the next wait
                next_s.wait_for_event_instr = WFE_RUN;
                if (evt) begin
                    next_s.evt_latched = 1'b1;
                end
            end
            default: begin
                next_s.wait_for_event_instr = WFE_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.rdata <= 32'h0000_0000;
            s.slverr <= 1'b0;
            s.strap_done <= 1'b0;
            s.byte_order <= `CTRL_RESET;
            s.sec_prio <= `CTRL_RESET;
            s.fault_ns <= `CTRL_RESET;
            s.rst_restrict <= `CTRL_RESET;
            s.rst_req <= `CTRL_RESET;
            s.clr_active <= 1'b0;
            s.wake_pend_s <= `CTRL_RESET;
            s.wake_pend_ns <= `CTRL_RESET;
            s.deep_lock <= `CTRL_RESET;
            s.deep_sel <= `CTRL_RESET;
            s.exit_sleep_s <= `CTRL_RESET;
            s.exit_sleep_ns <= `CTRL_RESET;
            s.evt_latched <= 1'b0;
            s.sleep_req <= 1'b0;
            s.wait_for_event_instr <= WFE_RUN;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    assign prdata = s.rdata;
    assign pslverr = s.slverr;
    assign big_endian = s.byte_order;
    assign nonsecure_deprioritized = s.sec_prio;
    assign fault_target_nonsecure = s.fault_ns;
    assign reset_secure_only = s.rst_restrict;
    assign sys_reset_request = s.rst_req;
    assign clear_active_pulse = s.clr_active;
    assign wfe_state = s.wait_for_event_instr;
    assign wfe_wake = (s.wait_for_event_instr == WFE_WAKE);
    assign event_latched = s.evt_latched;
    assign deep_sleep = s.deep_sel;
    assign sleep_on_exit_req = s.sleep_req;

endmodule : system_control_reset_sleep_regs

`default_nettype wire

// *** test/core_model.sv ***
// Core and power controller stand-in that drives status levels and event pulses.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock
    input wire logic pclk,
    // Pulses: pend, pend enabled, send event, external, wait, handler exit
    output logic [5:0] ev,
    // Levels
    output logic cpu_secure,
    output logic cpu_halted,
    output logic big_endian_strap
);
    initial begin
        ev = 6'h0;
        cpu_secure = 1'b1;
        cpu_halted = 1'b0;
        big_endian_strap = 1'b1;
    end
    // One-cycle pulse, launched just after an edge
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask : pulse
    task automatic strap(input logic v);
        @(posedge pclk);
        big_endian_strap <= v;
    endtask : strap
    task automatic mode(input logic s, input logic h);
        @(posedge pclk);
        cpu_secure <= s;
        cpu_halted <= h;
    endtask : mode
endmodule : core_model
`default_nettype wire

// *** test/sysctl_checker.sv ***
// Port assertions for the reset and sleep control register pair.
`timescale 1ns/1ps
`default_nettype none
module sysctl_checker
    import sysctl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    // Core side
    input wire logic cpu_halted,
    input wire logic sev_exec,
    input wire logic wfe_exec,
    input wire logic handler_return_thread,
    input wire logic reset_secure_only,
    input wire logic sys_reset_request,
    input wire logic clear_active_pulse,
    input wire sysctl_pkg::wfe_state_t wfe_state,
    input wire logic wfe_wake,
    input wire logic event_latched,
    input wire logic sleep_on_exit_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_stat;
        psel && penable && !pwrite && paddr == 12'h000 |-> prdata[31:16] == 16'hFA05;
    endproperty
    a_stat: assert property (p_stat) else $error("key status wrong");
    // Request only from a keyed write that the restriction allows
    property p_rst;
        $rose(sys_reset_request) |-> $past(psel && penable && pwrite && paddr == 12'h000
            && pwdata[31:16] == 16'h05FA && pwdata[2] && !(pprot[1] && reset_secure_only));
    endproperty
    a_rst: assert property (p_rst) else $error("reset request cause");
    property p_hold;
        sys_reset_request |=> sys_reset_request;
    endproperty
    a_hold: assert property (p_hold) else $error("reset request dropped");
    property p_clr;
        clear_active_pulse |-> $past(cpu_halted && psel && penable && pwrite && pwdata[1]) ##1 !clear_active_pulse;
    endproperty
    a_clr: assert property (p_clr) else $error("clear active pulse");
    property p_wake;
        wfe_wake |-> wfe_state == WFE_WAKE ##1 !wfe_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse");
    property p_sev;
        wfe_state == WFE_WAIT && sev_exec |=> wfe_wake;
    endproperty
    a_sev: assert property (p_sev) else $error("send event no wake");
    property p_lat;
        wfe_state == WFE_RUN && sev_exec && !wfe_exec |=> event_latched;
    endproperty
    a_lat: assert property (p_lat) else $error("event not latched");
    property p_exit;
        sleep_on_exit_req |-> $past(handler_return_thread) ##1 !sleep_on_exit_req;
    endproperty
    a_exit: assert property (p_exit) else $error("sleep on exit pulse");
    property p_ro;
        psel && penable && pwrite && pprot[1] && paddr == 12'h000 |=> $stable(reset_secure_only);
    endproperty
    a_ro: assert property (p_ro) else $error("restriction written from non-secure");
endmodule : sysctl_checker
bind system_control_reset_sleep_regs sysctl_checker sysctl_checker_inst(.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pprot, .prdata, .cpu_halted, .sev_exec, .wfe_exec, .handler_return_thread,
    .reset_secure_only, .sys_reset_request, .clear_active_pulse, .wfe_state, .wfe_wake, .event_latched,
    .sleep_on_exit_req);
`default_nettype wire

// *** test/system_control_reset_sleep_regs_tb.sv ***
// Register and low-power behaviour tests for the control register pair.
`timescale 1ns/1ps
`default_nettype none
module system_control_reset_sleep_regs_tb;
    import sysctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] pprot;
    logic [3:0] pstrb;
    logic [5:0] ev;
    logic cpu_secure, cpu_halted, big_endian_strap, big_endian, nonsecure_deprioritized;
    logic fault_target_nonsecure, reset_secure_only, sys_reset_request, clear_active_pulse;
    logic wfe_wake, event_latched, deep_sleep, sleep_on_exit_req;
    wfe_state_t wfe_state;
    int n_fail, checks;
    system_control_reset_sleep_regs system_control_reset_sleep_regs_inst(.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .big_endian_strap,
        .cpu_secure, .cpu_halted, .irq_became_pending(ev[0]), .irq_en_became_pending(ev[1]),
        .sev_exec(ev[2]), .ext_event(ev[3]), .wfe_exec(ev[4]), .handler_return_thread(ev[5]), .big_endian,
        .nonsecure_deprioritized, .fault_target_nonsecure, .reset_secure_only, .sys_reset_request,
        .clear_active_pulse, .wfe_state, .wfe_wake, .event_latched, .deep_sleep, .sleep_on_exit_req);
    core_model core_model_inst(.pclk, .ev, .cpu_secure, .cpu_halted, .big_endian_strap);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h got %h", n, e, g);
        end
    endtask : chk
    // Setup then access; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns,
        input logic [3:0] s = 4'hF);
        @(posedge pclk);
        psel <= 1'b1;
        pstrb <= s;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= {1'b0, ns, 1'b0};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic ns, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, ns);
        chk("prdata", e, rd);
    endtask : rchk
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pprot, pstrb} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(12'h000, 1'b0, 32'hFA05_8000);
        chk("endian", 32'h1, big_endian);
        rchk(12'h004, 1'b0, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_6008, 1'b0);
        rchk(12'h000, 1'b0, 32'hFA05_8000);
        apb(1'b1, 12'h000, 32'h05FA_7FFA, 1'b0);
        rchk(12'h000, 1'b0, 32'hFA05_E008);
        chk("ctl", 32'h7, {nonsecure_deprioritized, fault_target_nonsecure, reset_secure_only});
        rchk(12'h000, 1'b1, 32'hFA05_E000);
        apb(1'b1, 12'h000, 32'h05FA_0004, 1'b1);
        rchk(12'h000, 1'b0, 32'hFA05_E008);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF, 1'b0);
        rchk(12'h004, 1'b0, 32'h0000_001E);
        rchk(12'h004, 1'b1, 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_0016, 1'b1);
        rchk(12'h004, 1'b1, 32'h0000_0012);
        chk("deep", 32'h1, deep_sleep);
        apb(1'b1, 12'h004, 32'h0000_0016, 1'b0);
        apb(1'b1, 12'h004, 32'h0000_0002, 1'b1);
        rchk(12'h004, 1'b0, 32'h0000_0012);
        chk("deep", 32'h0, deep_sleep);
        core_model_inst.mode(1'b0, 1'b0);
        core_model_inst.pulse(4);
        core_model_inst.pulse(0);
        #1 chk("wfe", WFE_WAIT, wfe_state);
        core_model_inst.mode(1'b1, 1'b0);
        core_model_inst.pulse(0);
        #1 chk("wake", 32'h1, wfe_wake);
        core_model_inst.pulse(2);
        #1 chk("latch", 32'h1, event_latched);
        core_model_inst.pulse(4);
        #1 chk("wake", 32'h1, wfe_wake);
        core_model_inst.pulse(4);
        core_model_inst.pulse(3);
        #1 chk("wake", 32'h1, wfe_wake);
        core_model_inst.pulse(4);
        core_model_inst.pulse(2);
        core_model_inst.pulse(5);
        #1 chk("exit", 32'h1, sleep_on_exit_req);
        core_model_inst.mode(1'b1, 1'b1);
        apb(1'b1, 12'h000, 32'h05FA_6002, 1'b0);
        #1 chk("clr", 32'h1, clear_active_pulse);
        rchk(12'h000, 1'b0, 32'hFA05_E000);
        core_model_inst.mode(1'b1, 1'b0);
        apb(1'b0, 12'h008, 32'h0000_0000, 1'b0);
        chk("err", 32'h1, err);
        apb(1'b1, 12'h000, 32'h05FA_0004, 1'b0, 4'h3);
        apb(1'b1, 12'h000, 32'h05FA_0004, 1'b0, 4'hC);
        chk("rst", 32'h0, sys_reset_request);
        apb(1'b1, 12'h000, 32'h05FA_6004, 1'b1);
        rchk(12'h000, 1'b0, 32'hFA05_E004);
        chk("rst", 32'h1, sys_reset_request);
        core_model_inst.strap(1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(12'h000, 1'b0, 32'hFA05_0000);
        chk("rst", 32'h0, sys_reset_request);
        chk("endian", 32'h0, big_endian);
        end_sim;
    end
endmodule : system_control_reset_sleep_regs_tb
`default_nettype wire
